/* shared/cmp_irq_pkg.sv */
package cmp_irq_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_IRQ_CONTROL = 8'h0b;
  localparam logic [7:0] IDX_PERIPH_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_CMP_CONTROL = 8'h1f;
  localparam logic [7:0] IDX_PORT_A_DIR = 8'h85;
  localparam logic [7:0] IDX_PERIPH_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_VREF_CONTROL = 8'h9f;
  localparam logic [7:0] IDX_PORT_A = 8'h05;
  localparam logic [7:0] IDX_WAKE_STATUS = 8'h90;

  // Comparator control field positions
  localparam int CMP2_RESULT_BIT = 7;
  localparam int CMP1_RESULT_BIT = 6;
  localparam int INPUT_SWITCH_BIT = 3;
  localparam int MODE_MSB = 2;

  // Flag, enable and interrupt control bit positions
  localparam int CMP_FLAG_BIT = 6;
  localparam int CMP_ENABLE_BIT = 6;
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PERIPH_EN_BIT = 6;

  // Reset values
  localparam logic [7:0] RST_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIPH_FLAGS = 8'h00;
  localparam logic [7:0] RST_CMP_CONTROL = 8'h00;
  localparam logic [7:0] RST_PORT_A_DIR = 8'h1f;
  localparam logic [7:0] RST_PERIPH_ENABLES = 8'h00;
  localparam logic [7:0] RST_VREF_CONTROL = 8'h00;
  localparam logic [4:0] RST_PORT_A_LATCH = 5'h00;

  // Comparator mode codes
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [2:0] MODE_PIN_OUT = 3'h6;
  localparam logic [2:0] MODE_OFF = 3'h7;

  // Analog masks for port A bits 3..0 per mode
  localparam logic [4:0] ANALOG_ALL = 5'h0f;
  localparam logic [4:0] ANALOG_PIN_OUT = 5'h07;
  localparam logic [4:0] ANALOG_NONE = 5'h00;

  // Processor phase timing: four clocks to an instruction cycle
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  // Sequencer after a wake-up
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_NEXT_INSTR = 3'b010,
    SEQ_VECTOR = 3'b100
  } wake_seq_e;

  // APB request from master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  // APB answer from slave
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

endpackage

/* hw/cmp_irq_ctrl.sv */
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
// Operation
// - Comparator result bits are read-only.
// - Mode 110 routes raw outputs to pins.
// - Direction bits still gate shared pin drivers.
// - Analog pins read zero on port read.
// - Output change sets comparator interrupt flag.
// - Flag bit 6; write zero clears, one sets.
// - Request needs all three enables set.
// - Flag sets even with enables clear.
// - Change at read Q2 may miss flag.
// - Persisting mismatch keeps setting the flag.
// - Comparators run in sleep, wake device.
// - Mode 111 turns both comparators off.
// - Wake-up leaves comparator control unchanged.
// - Reset loads control register, mode 000.
// - Comparators powered down throughout reset.
// - Comparator wake reads flag bit one.
// - After wake with global enable set, next instruction, then vector.
module cmp_irq_ctrl #(
  parameter int PORT_WIDTH = 5
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Register bus
  input wire cmp_irq_pkg::apb_req_s apb_in,
  output cmp_irq_pkg::apb_rsp_s apb_out,
  // Analog comparator side
  input wire logic cmp1_raw_in,
  input wire logic cmp2_raw_in,
  output logic cmp_power_out,
  output logic input_switch_out,
  output logic [2:0] comparator_mode_field_out,
  output logic [7:0] vref_control_out,
  // Port A pins
  input wire logic [PORT_WIDTH-1:0] port_a_pins_in,
  output logic [PORT_WIDTH-1:0] port_a_data_out,
  output logic [PORT_WIDTH-1:0] port_a_oe_out,
  output logic shared_pin_three_out,
  output logic shared_pin_four_out,
  // Processor side
  input wire logic sleep_in,
  output logic cmp_irq_out,
  output logic wake_out,
  output logic vector_load_out,
  output logic [12:0] vector_addr_out
);

  // Software-visible registers
  logic [7:0] irq_control_reg, irq_control_next;
  logic comparator_irq_flag_reg, comparator_irq_flag_next;
  logic comparator_irq_enable_reg, comparator_irq_enable_next;
  logic [3:0] comparator_control_reg, comparator_control_next; // Input switch and mode
  logic [PORT_WIDTH-1:0] port_a_direction_reg, port_a_direction_next;
  logic [PORT_WIDTH-1:0] port_a_latch_reg, port_a_latch_next;
  logic [7:0] vref_control_reg, vref_control_next;
  logic wake_by_cmp_reg, wake_by_cmp_next; // Sticky wake cause

  // Comparator result path
  logic [1:0] cmp_sync1_reg; // First stage, read only by second
  logic [1:0] cmp_sync2_reg;
  logic [1:0] cmp_ref_reg, cmp_ref_next; // Reference latch

  // Bus answer registers
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;

  // Phase, wake and output registers
  logic [1:0] phase_reg, phase_next;
  cmp_irq_pkg::wake_seq_e seq_reg, seq_next;
  logic [1:0] seq_cnt_reg, seq_cnt_next;
  logic cmp_irq_reg, cmp_irq_next;
  logic wake_reg, wake_next;
  logic vector_load_reg, vector_load_next;
  logic cmp_power_reg, cmp_power_next;
  logic pin_sel_reg, pin_sel_next; // Pins carry raw comparator outputs
  logic [PORT_WIDTH-1:0] port_oe_reg, port_oe_next;
  logic [PORT_WIDTH-1:0] port_data_reg, port_data_next;

  // Decode helpers
  logic [7:0] reg_idx;
  logic addr_ok;
  logic setup_phase;
  logic access_done;
  logic wr_en;
  logic rd_en;
  logic cmp_access;
  logic mismatch;
  logic flag_set;
  logic [2:0] cur_mode;
  logic [PORT_WIDTH-1:0] analog_mask;

  assign reg_idx = apb_in.paddr[9:2];
  assign addr_ok = (apb_in.paddr[1:0] == 2'h0) && (apb_in.paddr[11:10] == 2'h0);
  assign setup_phase = apb_in.psel && !apb_in.penable;
  assign access_done = apb_in.psel && apb_in.penable && pready_reg;
  assign wr_en = access_done && apb_in.pwrite && !pslverr_reg;
  assign rd_en = access_done && !apb_in.pwrite && !pslverr_reg;
  assign cur_mode = comparator_control_reg[cmp_irq_pkg::MODE_MSB:0];

  // Any completed read or write of the comparator control register
  assign cmp_access = (rd_en || wr_en) && (reg_idx == cmp_irq_pkg::IDX_CMP_CONTROL);

  // Analog pins per mode
  always_comb begin
    analog_mask = '0;
    case (cur_mode)
      cmp_irq_pkg::MODE_OFF: begin
        analog_mask = PORT_WIDTH'(cmp_irq_pkg::ANALOG_NONE);
      end
      cmp_irq_pkg::MODE_PIN_OUT: begin
        analog_mask = PORT_WIDTH'(cmp_irq_pkg::ANALOG_PIN_OUT);
      end
      default: begin
        // Reset mode and the other modes keep the inputs analog
        analog_mask = PORT_WIDTH'(cmp_irq_pkg::ANALOG_ALL);
      end
    endcase
  end

  // Mismatch between live results and the reference latch
  assign mismatch = (cmp_sync2_reg != cmp_ref_reg);

  // A change landing on a control read at Q2 is dropped
  assign flag_set = mismatch && !(cmp_access && !apb_in.pwrite &&
                    (phase_reg == cmp_irq_pkg::PHASE_Q2));

  // Synchroniser for the raw comparator outputs
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cmp_sync1_reg <= 2'h0;
      cmp_sync2_reg <= 2'h0;
    end else begin
      cmp_sync1_reg <= {cmp2_raw_in, cmp1_raw_in};
      cmp_sync2_reg <= cmp_sync1_reg;
    end
  end

  // Register file next values
  always_comb begin
    irq_control_next = irq_control_reg;
    comparator_irq_enable_next = comparator_irq_enable_reg;
    comparator_control_next = comparator_control_reg;
    port_a_direction_next = port_a_direction_reg;
    port_a_latch_next = port_a_latch_reg;
    vref_control_next = vref_control_reg;
    comparator_irq_flag_next = comparator_irq_flag_reg;
    wake_by_cmp_next = wake_by_cmp_reg;
    cmp_ref_next = cmp_ref_reg;
    if (wr_en) begin
      case (reg_idx)
        cmp_irq_pkg::IDX_IRQ_CONTROL: begin
          irq_control_next = apb_in.pwdata[7:0];
        end
        cmp_irq_pkg::IDX_CMP_CONTROL: begin
          // Result bits ignore writes
          comparator_control_next = apb_in.pwdata[3:0];
        end
        cmp_irq_pkg::IDX_PORT_A_DIR: begin
          port_a_direction_next = apb_in.pwdata[PORT_WIDTH-1:0];
        end
        cmp_irq_pkg::IDX_PORT_A: begin
          port_a_latch_next = apb_in.pwdata[PORT_WIDTH-1:0];
        end
        cmp_irq_pkg::IDX_PERIPH_ENABLES: begin
          comparator_irq_enable_next = apb_in.pwdata[cmp_irq_pkg::CMP_ENABLE_BIT];
        end
        cmp_irq_pkg::IDX_VREF_CONTROL: begin
          vref_control_next = apb_in.pwdata[7:0];
        end
        cmp_irq_pkg::IDX_WAKE_STATUS: begin
          // Writing one clears the wake cause
          if (apb_in.pwdata[0]) begin
            wake_by_cmp_next = 1'b0;
          end
        end
        cmp_irq_pkg::IDX_PERIPH_FLAGS: begin
          // Zero clears, one sets as a simulated interrupt
          comparator_irq_flag_next = apb_in.pwdata[cmp_irq_pkg::CMP_FLAG_BIT];
        end
        default: begin
          // Nothing else is writable
        end
      endcase
    end
    // Any control access ends the mismatch by reloading the reference
    if (cmp_access) begin
      cmp_ref_next = cmp_sync2_reg;
    end
    // Hardware set wins over a software clear, regardless of enables
    if (flag_set) begin
      comparator_irq_flag_next = 1'b1;
    end
    // Comparator wake is remembered; flag already reads one
    if (sleep_in && flag_set && comparator_irq_enable_reg) begin
      wake_by_cmp_next = 1'b1;
    end
  end

  // Register file storage
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_control_reg <= cmp_irq_pkg::RST_IRQ_CONTROL;
      comparator_irq_enable_reg <= cmp_irq_pkg::RST_PERIPH_ENABLES[cmp_irq_pkg::CMP_ENABLE_BIT];
      comparator_control_reg <= cmp_irq_pkg::RST_CMP_CONTROL[3:0];
      port_a_direction_reg <= cmp_irq_pkg::RST_PORT_A_DIR[PORT_WIDTH-1:0];
      port_a_latch_reg <= cmp_irq_pkg::RST_PORT_A_LATCH[PORT_WIDTH-1:0];
      vref_control_reg <= cmp_irq_pkg::RST_VREF_CONTROL;
      comparator_irq_flag_reg <= cmp_irq_pkg::RST_PERIPH_FLAGS[cmp_irq_pkg::CMP_FLAG_BIT];
      wake_by_cmp_reg <= 1'b0;
      cmp_ref_reg <= 2'h0;
    end else begin
      // Sleep never touches the control register
      irq_control_reg <= irq_control_next;
      comparator_irq_enable_reg <= comparator_irq_enable_next;
      comparator_control_reg <= comparator_control_next;
      port_a_direction_reg <= port_a_direction_next;
      port_a_latch_reg <= port_a_latch_next;
      vref_control_reg <= vref_control_next;
      comparator_irq_flag_reg <= comparator_irq_flag_next;
      wake_by_cmp_reg <= wake_by_cmp_next;
      cmp_ref_reg <= cmp_ref_next;
    end
  end

  // Bus answer: ready in the first access cycle, data prepared in setup
  always_comb begin
    pready_next = setup_phase;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    if (setup_phase) begin
      prdata_next = 32'h0000_0000;
      pslverr_next = !addr_ok;
      if (addr_ok) begin
        case (reg_idx)
          cmp_irq_pkg::IDX_IRQ_CONTROL: begin
            prdata_next[7:0] = irq_control_reg;
          end
          cmp_irq_pkg::IDX_PERIPH_FLAGS: begin
            prdata_next[cmp_irq_pkg::CMP_FLAG_BIT] = comparator_irq_flag_reg;
          end
          cmp_irq_pkg::IDX_CMP_CONTROL: begin
            // Results come from the synchronised copy
            prdata_next[cmp_irq_pkg::CMP2_RESULT_BIT] = cmp_sync2_reg[1];
            prdata_next[cmp_irq_pkg::CMP1_RESULT_BIT] = cmp_sync2_reg[0];
            prdata_next[3:0] = comparator_control_reg;
          end
          cmp_irq_pkg::IDX_PORT_A_DIR: begin
            prdata_next[PORT_WIDTH-1:0] = port_a_direction_reg;
          end
          cmp_irq_pkg::IDX_PORT_A: begin
            // Analog pins read as zero
            prdata_next[PORT_WIDTH-1:0] = port_a_pins_in & ~analog_mask;
          end
          cmp_irq_pkg::IDX_PERIPH_ENABLES: begin
            prdata_next[cmp_irq_pkg::CMP_ENABLE_BIT] = comparator_irq_enable_reg;
          end
          cmp_irq_pkg::IDX_VREF_CONTROL: begin
            prdata_next[7:0] = vref_control_reg;
          end
          cmp_irq_pkg::IDX_WAKE_STATUS: begin
            prdata_next[0] = wake_by_cmp_reg;
          end
          default: begin
            // Unmapped index answers with an error
            pslverr_next = 1'b1;
          end
        endcase
      end
    end
  end

  // Bus answer storage
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // Wake and vector sequencer, plus phase and pin control
  always_comb begin
    phase_next = phase_reg + 2'h1;
    seq_next = seq_reg;
    seq_cnt_next = seq_cnt_reg;
    wake_next = 1'b0;
    vector_load_next = 1'b0;
    // All three enables gate the request
    cmp_irq_next = comparator_irq_flag_reg && comparator_irq_enable_reg &&
                   irq_control_reg[cmp_irq_pkg::PERIPH_EN_BIT] &&
                   irq_control_reg[cmp_irq_pkg::GLOBAL_EN_BIT];
    // Off only in mode 111; held off by reset
    cmp_power_next = (cur_mode != cmp_irq_pkg::MODE_OFF);
    pin_sel_next = (cur_mode == cmp_irq_pkg::MODE_PIN_OUT);
    port_oe_next = ~port_a_direction_reg;
    port_data_next = port_a_latch_reg;
    case (seq_reg)
      cmp_irq_pkg::SEQ_IDLE: begin
        // Comparators keep running; enabled flag wakes the core
        if (sleep_in && comparator_irq_flag_reg && comparator_irq_enable_reg &&
            irq_control_reg[cmp_irq_pkg::PERIPH_EN_BIT]) begin
          wake_next = 1'b1;
          if (irq_control_reg[cmp_irq_pkg::GLOBAL_EN_BIT]) begin
            seq_next = cmp_irq_pkg::SEQ_NEXT_INSTR;
            seq_cnt_next = 2'h0;
          end
        end
      end
      cmp_irq_pkg::SEQ_NEXT_INSTR: begin
        // Let one full instruction cycle run
        seq_cnt_next = seq_cnt_reg + 2'h1;
        if (seq_cnt_reg == cmp_irq_pkg::PHASE_Q4) begin
          seq_next = cmp_irq_pkg::SEQ_VECTOR;
        end
      end
      cmp_irq_pkg::SEQ_VECTOR: begin
        vector_load_next = 1'b1;
        seq_next = cmp_irq_pkg::SEQ_IDLE;
      end
      default: begin
        seq_next = cmp_irq_pkg::SEQ_IDLE;
      end
    endcase
  end

  // Sequencer and output storage
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_reg <= cmp_irq_pkg::PHASE_Q1;
      seq_reg <= cmp_irq_pkg::SEQ_IDLE;
      seq_cnt_reg <= 2'h0;
      wake_reg <= 1'b0;
      vector_load_reg <= 1'b0;
      cmp_irq_reg <= 1'b0;
      cmp_power_reg <= 1'b0;
      pin_sel_reg <= 1'b0;
      port_oe_reg <= '0;
      port_data_reg <= '0;
    end else begin
      phase_reg <= phase_next;
      seq_reg <= seq_next;
      seq_cnt_reg <= seq_cnt_next;
      wake_reg <= wake_next;
      vector_load_reg <= vector_load_next;
      cmp_irq_reg <= cmp_irq_next;
      cmp_power_reg <= cmp_power_next;
      pin_sel_reg <= pin_sel_next;
      port_oe_reg <= port_oe_next;
      port_data_reg <= port_data_next;
    end
  end

  // Outputs
  assign apb_out.pready = pready_reg;
  assign apb_out.pslverr = pslverr_reg;
  assign apb_out.prdata = prdata_reg;
  assign cmp_power_out = cmp_power_reg;
  assign input_switch_out = comparator_control_reg[cmp_irq_pkg::INPUT_SWITCH_BIT];
  assign comparator_mode_field_out = cur_mode;
  assign vref_control_out = vref_control_reg;
  assign port_a_data_out = port_data_reg;
  assign port_a_oe_out = port_oe_reg;
  // Pin path is deliberately unsynchronised in pin-output mode
  assign shared_pin_three_out = pin_sel_reg ? cmp1_raw_in : port_data_reg[3];
  assign shared_pin_four_out = pin_sel_reg ? cmp2_raw_in : port_data_reg[4];
  assign cmp_irq_out = cmp_irq_reg;
  assign wake_out = wake_reg;
  assign vector_load_out = vector_load_reg;
  assign vector_addr_out = cmp_irq_pkg::IRQ_VECTOR;

endmodule

/* tb/cmp_irq_sva.sv */
`timescale 1ns/100ps
module cmp_irq_sva #(
  parameter int PORT_WIDTH = 5
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Register bus
  input wire cmp_irq_pkg::apb_req_s apb_in,
  input wire cmp_irq_pkg::apb_rsp_s apb_out,
  // Comparator and pin side
  input wire logic cmp1_raw_in,
  input wire logic cmp2_raw_in,
  input wire logic cmp_power_out,
  input wire logic [2:0] comparator_mode_field_out,
  input wire logic [PORT_WIDTH-1:0] port_a_data_out,
  input wire logic shared_pin_three_out,
  input wire logic shared_pin_four_out,
  // Processor side
  input wire logic sleep_in,
  input wire logic wake_out,
  input wire logic vector_load_out,
  input wire logic [12:0] vector_addr_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  // Setup of a read of the pin register; the check adds reset mode, where every low pin is analog
  logic port_rd;
  assign port_rd = apb_in.psel && !apb_in.penable && !apb_in.pwrite
    && apb_in.paddr == {2'b00, cmp_irq_pkg::IDX_PORT_A, 2'b00};

  ready_one_a: assert property (apb_in.psel && !apb_in.penable |=> apb_out.pready)
    else $error("pready missing after setup");
  err_pair_a: assert property (apb_out.pslverr |-> apb_out.pready)
    else $error("pslverr without pready");
  pin_three_a: assert property (
    shared_pin_three_out == ($past(comparator_mode_field_out) == cmp_irq_pkg::MODE_PIN_OUT
      ? cmp1_raw_in : port_a_data_out[3]))
    else $error("pin three source wrong");
  pin_four_a: assert property (
    shared_pin_four_out == ($past(comparator_mode_field_out) == cmp_irq_pkg::MODE_PIN_OUT
      ? cmp2_raw_in : port_a_data_out[4]))
    else $error("pin four source wrong");
  mode_off_a: assert property (
    (comparator_mode_field_out == cmp_irq_pkg::MODE_OFF) [*2] |-> !cmp_power_out)
    else $error("comparators powered in off mode");
  port_analog_a: assert property (
    port_rd && comparator_mode_field_out == cmp_irq_pkg::MODE_RESET
      |=> apb_out.prdata[3:0] == 4'h0)
    else $error("analog pin read not zero");
  reset_mode_a: assert property (
    $fell(rst_in) |-> comparator_mode_field_out == cmp_irq_pkg::MODE_RESET)
    else $error("mode not cleared by reset");
  wake_sleep_a: assert property (wake_out |-> $past(sleep_in))
    else $error("wake pulse while awake");
  vector_addr_a: assert property (
    vector_load_out |-> vector_addr_out == cmp_irq_pkg::IRQ_VECTOR && !$past(vector_load_out)
      && $past(wake_out, 5))
    else $error("vector load wrong");

  // Main scenarios reached
  pin_mode_c: cover property (comparator_mode_field_out == cmp_irq_pkg::MODE_PIN_OUT);
  wake_c: cover property (wake_out);
  vector_c: cover property (vector_load_out);
  refuse_c: cover property (apb_out.pslverr);
endmodule

/* tb/cmp_far_model.sv */
`timescale 1ns/100ps
module cmp_far_model (
  // Comparator levels chosen by the bench
  input wire logic level1_in,
  input wire logic level2_in,
  // Pin drive from the block
  input wire logic [4:0] oe_in,
  input wire logic [4:0] data_in,
  input wire logic pin3_in,
  input wire logic pin4_in,
  // Raw outputs and resolved pin levels
  output logic raw1_out,
  output logic raw2_out,
  output logic [4:0] pins_out
);
  // Drive seen on each pin when the block enables it
  logic [4:0] drv;
  assign drv = {pin4_in, pin3_in, data_in[2:0]};
  // Comparators answer at once with the analog level
  assign raw1_out = level1_in;
  assign raw2_out = level2_in;
  // Undriven pins float to the external pull-up
  assign pins_out = (oe_in & drv) | ~oe_in;
endmodule

/* tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
  // Clock, reset and bus
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  cmp_irq_pkg::apb_req_s req = '0;
  cmp_irq_pkg::apb_rsp_s rsp;
  // Analog levels and sleep request
  logic lvl1 = 1'b0;
  logic lvl2 = 1'b0;
  logic sleep = 1'b0;
  // Design outputs and partner wires
  logic raw1, raw2, power, isw, pin3, pin4, irq, wake, vload;
  logic [2:0] mode;
  logic [7:0] vref;
  logic [4:0] pins, pdata, poe;
  logic [12:0] vaddr;
  // Last bus answer and counters
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int checked = 0;
  int i, n;
  // Register reset table
  logic [7:0] ridx [6] = '{cmp_irq_pkg::IDX_IRQ_CONTROL, cmp_irq_pkg::IDX_PERIPH_FLAGS,
    cmp_irq_pkg::IDX_CMP_CONTROL, cmp_irq_pkg::IDX_PORT_A_DIR,
    cmp_irq_pkg::IDX_PERIPH_ENABLES, cmp_irq_pkg::IDX_VREF_CONTROL};
  logic [7:0] rval [6] = '{8'h00, 8'h00, 8'h00, 8'h1f, 8'h00, 8'h00};
  // Mode table for the pin tests
  logic [2:0] pmode [3] = '{3'h6, 3'h0, 3'h7};
  logic [7:0] pexp [3] = '{8'h08, 8'h00, 8'h07};

  // Free running clock
  always #5 mclk_in = ~mclk_in;

  cmp_irq_ctrl #(.PORT_WIDTH(5)) cmp_irq_ctrl_inst (
    .mclk_in(mclk_in), .rst_in(rst_in), .apb_in(req), .apb_out(rsp),
    .cmp1_raw_in(raw1), .cmp2_raw_in(raw2), .cmp_power_out(power),
    .input_switch_out(isw), .comparator_mode_field_out(mode), .vref_control_out(vref),
    .port_a_pins_in(pins), .port_a_data_out(pdata), .port_a_oe_out(poe),
    .shared_pin_three_out(pin3), .shared_pin_four_out(pin4), .sleep_in(sleep),
    .cmp_irq_out(irq), .wake_out(wake), .vector_load_out(vload), .vector_addr_out(vaddr));

  cmp_far_model cmp_far_model_inst (
    .level1_in(lvl1), .level2_in(lvl2), .oe_in(poe), .data_in(pdata), .pin3_in(pin3),
    .pin4_in(pin4), .raw1_out(raw1), .raw2_out(raw2), .pins_out(pins));

  // Closing report
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h want %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    @(posedge mclk_in);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'b00, idx, 2'b00},
      pwdata: {24'h000000, wd}};
    @(posedge mclk_in);
    req.penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk_in);
      if (rsp.pready === 1'b1) break;
    end
    if (k == 20) begin
      n_errors++;
      give_verdict();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge mclk_in);
    check(power, 1'b0);
    rst_in <= 1'b0; // Released on a rising edge
    for (i = 0; i < 6; i++) begin
      xfer(1'b0, ridx[i], 8'h00);
      check(rd, {24'h000000, rval[i]});
    end
    $display("test reset values done");
    // Result bits ignore writes
    xfer(1'b1, cmp_irq_pkg::IDX_CMP_CONTROL, 8'hc5);
    xfer(1'b0, cmp_irq_pkg::IDX_CMP_CONTROL, 8'h00);
    check(rd, 32'h05);
    $display("test read only results done");
    // Change of comparator one sets the flag with all enables clear
    lvl1 <= 1'b1;
    repeat (6) @(posedge mclk_in);
    xfer(1'b0, cmp_irq_pkg::IDX_PERIPH_FLAGS, 8'h00);
    check(rd, 32'h40);
    xfer(1'b1, cmp_irq_pkg::IDX_PERIPH_FLAGS, 8'h00);
    xfer(1'b0, cmp_irq_pkg::IDX_PERIPH_FLAGS, 8'h00);
    check(rd, 32'h40);
    xfer(1'b0, cmp_irq_pkg::IDX_CMP_CONTROL, 8'h00);
    check(rd, 32'h45);
    xfer(1'b1, cmp_irq_pkg::IDX_PERIPH_FLAGS, 8'h00);
    xfer(1'b0, cmp_irq_pkg::IDX_PERIPH_FLAGS, 8'h00);
    check(rd, 32'h00);
    xfer(1'b1, cmp_irq_pkg::IDX_PERIPH_FLAGS, 8'h40);
    xfer(1'b0, cmp_irq_pkg::IDX_PERIPH_FLAGS, 8'h00);
    check(rd, 32'h40);
    $display("test flag done");
    // Every combination of the three enables
    for (i = 0; i < 8; i++) begin
      xfer(1'b1, cmp_irq_pkg::IDX_PERIPH_ENABLES, {1'b0, i[0], 6'h00});
      xfer(1'b1, cmp_irq_pkg::IDX_IRQ_CONTROL, {i[2], i[1], 6'h00});
      repeat (3) @(posedge mclk_in);
      check(irq, i == 7);
    end
    $display("test enables done");
    // Comparator two changes while asleep
    xfer(1'b1, cmp_irq_pkg::IDX_PERIPH_FLAGS, 8'h00);
    sleep <= 1'b1;
    lvl2 <= 1'b1;
    for (n = 0; n < 50 && wake !== 1'b1; n++) @(posedge mclk_in);
    check(wake, 1'b1);
    if (n == 50) give_verdict();
    for (n = 0; n < 50 && vload !== 1'b1; n++) @(posedge mclk_in);
    check(vload, 1'b1);
    check(vaddr, 13'h0004);
    if (n == 50) give_verdict();
    sleep <= 1'b0;
    xfer(1'b0, cmp_irq_pkg::IDX_PERIPH_FLAGS, 8'h00);
    check(rd, 32'h40);
    xfer(1'b0, cmp_irq_pkg::IDX_CMP_CONTROL, 8'h00);
    check(rd, 32'hc5);
    // Wake cause is sticky until written with one
    xfer(1'b0, cmp_irq_pkg::IDX_WAKE_STATUS, 8'h00);
    check(rd, 32'h01);
    xfer(1'b1, cmp_irq_pkg::IDX_WAKE_STATUS, 8'h01);
    xfer(1'b0, cmp_irq_pkg::IDX_WAKE_STATUS, 8'h00);
    check(rd, 32'h00);
    $display("test sleep wake done");
    // Pin routing and analog masking per mode
    lvl2 <= 1'b0;
    xfer(1'b1, cmp_irq_pkg::IDX_PORT_A_DIR, 8'h07);
    for (i = 0; i < 3; i++) begin
      xfer(1'b1, cmp_irq_pkg::IDX_CMP_CONTROL, {5'h00, pmode[i]});
      xfer(1'b0, cmp_irq_pkg::IDX_PORT_A, 8'h00);
      check(rd, {24'h000000, pexp[i]});
      if (i == 0) begin
        check(poe, 5'h18);
        check({pin4, pin3}, 2'b01);
      end
    end
    check(power, 1'b0);
    // Latch drives the shared pins outside pin-output mode
    xfer(1'b1, cmp_irq_pkg::IDX_CMP_CONTROL, 8'h0f);
    xfer(1'b1, cmp_irq_pkg::IDX_PORT_A, 8'h10);
    xfer(1'b1, cmp_irq_pkg::IDX_VREF_CONTROL, 8'ha5);
    xfer(1'b0, cmp_irq_pkg::IDX_PORT_A, 8'h00);
    check(rd, 32'h17);
    check({vref, pdata, isw, pin4, pin3}, {8'ha5, 5'h10, 3'b110});
    xfer(1'b0, 8'h40, 8'h00);
    check(err, 1'b1);
    check(rd, 32'h00);
    $display("test pins and refusal done");
    give_verdict();
  end
endmodule

bind cmp_irq_ctrl cmp_irq_sva #(.PORT_WIDTH(PORT_WIDTH)) cmp_irq_sva_inst (
  .mclk_in(mclk_in), .rst_in(rst_in), .apb_in(apb_in), .apb_out(apb_out),
  .cmp1_raw_in(cmp1_raw_in), .cmp2_raw_in(cmp2_raw_in), .cmp_power_out(cmp_power_out),
  .comparator_mode_field_out(comparator_mode_field_out), .port_a_data_out(port_a_data_out),
  .shared_pin_three_out(shared_pin_three_out), .shared_pin_four_out(shared_pin_four_out),
  .sleep_in(sleep_in), .wake_out(wake_out), .vector_load_out(vector_load_out),
  .vector_addr_out(vector_addr_out));
